// >>> hw/jvp_top.sv
// Purpose: Jog velocity profile generator with AXI4-Lite registers
// Assumes: motion_tick and sync_tick are one-cycle pulses from aclk logic
// Notes: Rates are velocity change per motion tick, or per motion_tick that coincides with sync_tick for a synchronized profile
//
// How it works
// - Select low uses profile 0, high profile 1
// - Positive request jogs forward, release decelerates
// - Negative request jogs reverse, release decelerates
// - Negative profile velocity inverts jog direction
// - Both requests active: ramp to zero, ready
// - Negative during positive acts like release
// - Profile change mid-jog ramps between velocities
// - Requests act on level, not edges
// - Reversal decelerates to zero, then accelerates
// - No jog start while other motion busy
// - Stop overrides jog with stop deceleration
// - S-curve rates are whole-ramp averages
// - Each profile has realtime or synchronized timebase
// - Any-done sets at finish, clears on start
// - Accelerating flag while ramping toward target
// - At-velocity flag from target until decel
// - In-progress flag spans whole jog profile
// - Profile done holds until restart, not after stop
// - Decelerating flag until zero or new target
// - Jog allowed away from active travel limit
`timescale 1ns/1ps
`include "jvp_cfg.svh"

module jvp_top
    import jvp_pkg::*;
(
    input wire logic aclk, // 125 MHz clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [`JVP_AW-1:0] s_axi_awaddr, // Write address
    input wire logic [2:0] s_axi_awprot, // Unused
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Byte enables
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [`JVP_AW-1:0] s_axi_araddr, // Read address
    input wire logic [2:0] s_axi_arprot, // Unused
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic jog_positive_request, // Pin, positive jog level
    input wire logic jog_negative_request, // Pin, negative jog level
    input wire logic jog_profile_select, // Pin, profile 1 when high
    input wire logic stop_request, // Pin, stop override
    input wire logic limit_positive, // Pin, positive travel limit
    input wire logic limit_negative, // Pin, negative travel limit
    input wire logic homing_busy, // Homing in progress
    input wire logic index_busy, // Index in progress
    input wire logic program_busy, // Program motion in progress
    input wire logic motion_tick, // Motion update pulse
    input wire logic sync_tick, // Synchronized timebase pulse
    output logic signed [31:0] cmd_velocity, // Commanded velocity
    output logic any_jog_done_flag, // Any jog finished
    output logic jog_ready_flag, // No jog motion
    output logic [1:0] profile_done_flag, // Per-profile done
    output logic [1:0] accelerating_flag, // Per-profile accelerating
    output logic [1:0] at_target_speed_flag, // Per-profile at velocity
    output logic [1:0] decelerating_flag, // Per-profile decelerating
    output logic [1:0] jog_active_flag // Per-profile in progress
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] jvp_abs(input logic signed [31:0] x);
        jvp_abs = x[31] ? 32'(-x) : 32'(x);
    endfunction

    function automatic logic signed [31:0] jvp_step(input logic signed [31:0] cur,
                                                     input logic signed [31:0] tgt,
                                                     input logic [31:0] rate);
        logic signed [32:0] d;
        logic signed [32:0] r;
        d = $signed({tgt[31], tgt}) - $signed({cur[31], cur});
        r = $signed({1'b0, rate});
        if (d > r) begin
            jvp_step = 32'($signed({cur[31], cur}) + r);
        end else if (d < -r) begin
            jvp_step = 32'($signed({cur[31], cur}) - r);
        end else begin
            jvp_step = tgt;
        end
    endfunction

    function automatic logic [31:0] jvp_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        jvp_merge = (old & ~m) | (nw & m);
    endfunction

    function automatic logic [`JVP_AW-1:0] jvp_word(input logic [`JVP_AW-1:0] a);
        jvp_word = {a[`JVP_AW-1:2], 2'b00};
    endfunction

    jvp_state_t st_r;
    jvp_state_t st_nxt;
    logic [`JVP_NPIN-1:0] agree;
    logic pos, neg, sel, stp, lp, ln, busy, up, tb, step;
    logic signed [31:0] vsel, tgt, tgt_eff, nv;
    logic [31:0] rate;
    jvp_status_t stat;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        // Three-stage sampling; a change counts once stages two and three agree
        st_nxt.s1 = {limit_negative, limit_positive, stop_request,
                     jog_profile_select, jog_negative_request, jog_positive_request};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        agree = ~(st_r.s2 ^ st_r.s3);
        st_nxt.filt = (st_r.s3 & agree) | (st_r.filt & ~agree);

        pos = st_r.filt[`JVP_P_POS];
        neg = st_r.filt[`JVP_P_NEG];
        sel = st_r.filt[`JVP_P_SEL];
        stp = st_r.filt[`JVP_P_STOP];
        lp = st_r.filt[`JVP_P_LIMP];
        ln = st_r.filt[`JVP_P_LIMN];
        busy = homing_busy | index_busy | program_busy;

        // Target follows request levels every cycle
        vsel = sel ? st_r.regs.vel1 : st_r.regs.vel0;
        if (pos && !neg) begin
            tgt = vsel;
        end else if (neg && !pos) begin
            tgt = 32'(-vsel);
        end else begin
            tgt = '0;
        end
        if (st_r.mode == S_IDLE && busy) begin
            tgt = '0;
        end
        // Only motion into an active limit is blocked
        if ((tgt > 0 && lp) || (tgt < 0 && ln)) begin
            tgt = '0;
        end
        if (stp) begin
            tgt = '0;
        end
        // Opposite sign means ramp to zero first
        if (st_r.cmd != 0 && tgt != 0 && st_r.cmd[31] != tgt[31]) begin
            tgt_eff = '0;
        end else begin
            tgt_eff = tgt;
        end
        up = jvp_abs(tgt_eff) > jvp_abs(st_r.cmd);
        // S-curve shaping is not built; the linear ramp already runs at the average rate
        if (stp) begin
            rate = st_r.regs.sdec;
        end else if (up) begin
            rate = sel ? st_r.regs.acc1 : st_r.regs.acc0;
        end else begin
            rate = sel ? st_r.regs.dec1 : st_r.regs.dec0;
        end
        tb = sel ? st_r.regs.ctrl[`JVP_CTRL_TB1] : st_r.regs.ctrl[`JVP_CTRL_TB0];
        step = motion_tick && (!tb || sync_tick);
        nv = step ? jvp_step(st_r.cmd, tgt_eff, rate) : st_r.cmd;
        st_nxt.cmd = nv;

        case (st_r.mode)
            S_IDLE: begin
                if (!stp && tgt != 0) begin
                    st_nxt.mode = S_ACC;
                    st_nxt.act = sel;
                    st_nxt.done[sel] = 1'b0;
                    st_nxt.any_done = 1'b0;
                end
            end
            S_ACC, S_ATV, S_DEC: begin
                st_nxt.act = sel;
                if (stp) begin
                    st_nxt.mode = S_STOP;
                end else if (nv == 0 && tgt == 0) begin
                    st_nxt.mode = S_IDLE;
                    st_nxt.done[st_r.act] = 1'b1;
                    st_nxt.any_done = 1'b1;
                end else if (nv == tgt_eff && tgt_eff != 0) begin
                    st_nxt.mode = S_ATV;
                end else if (jvp_abs(tgt_eff) > jvp_abs(nv)) begin
                    st_nxt.mode = S_ACC;
                end else begin
                    st_nxt.mode = S_DEC;
                end
            end
            S_STOP: begin
                // A stopped jog ends without any done flag
                if (nv == 0) begin
                    st_nxt.mode = S_IDLE;
                end
            end
            default: begin
                st_nxt.mode = S_IDLE;
            end
        endcase

        for (int i = 0; i < 2; i++) begin
            st_nxt.acc[i] = (st_nxt.mode == S_ACC) && (st_nxt.act == 1'(i));
            st_nxt.atv[i] = (st_nxt.mode == S_ATV) && (st_nxt.act == 1'(i));
            st_nxt.dec[i] = (st_nxt.mode == S_DEC) && (st_nxt.act == 1'(i));
            st_nxt.inp[i] = (st_nxt.mode != S_IDLE) && (st_nxt.act == 1'(i));
        end
        st_nxt.ready = (st_nxt.mode == S_IDLE) && (nv == 0);

        // ****************************************
        // AXI4-Lite write channel
        // ****************************************
        if (st_r.axi.bvalid && s_axi_bready) begin
            st_nxt.axi.bvalid = 1'b0;
        end
        if (s_axi_awvalid && st_r.axi.awready) begin
            st_nxt.axi.aw_have = 1'b1;
            st_nxt.axi.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.axi.wready) begin
            st_nxt.axi.w_have = 1'b1;
            st_nxt.axi.wdata = s_axi_wdata;
            st_nxt.axi.wstrb = s_axi_wstrb;
        end
        if (st_nxt.axi.aw_have && st_nxt.axi.w_have && !st_r.axi.bvalid) begin
            st_nxt.axi.aw_have = 1'b0;
            st_nxt.axi.w_have = 1'b0;
            st_nxt.axi.bvalid = 1'b1;
            st_nxt.axi.bresp = `JVP_RESP_OKAY;
            case (jvp_word(st_nxt.axi.awaddr))
                `JVP_OFF_CTRL: st_nxt.regs.ctrl = `JVP_CTRL_W'(jvp_merge(32'(st_r.regs.ctrl),
                                                  st_nxt.axi.wdata, st_nxt.axi.wstrb));
                `JVP_OFF_VEL0: st_nxt.regs.vel0 = jvp_merge(st_r.regs.vel0, st_nxt.axi.wdata, st_nxt.axi.wstrb);
                `JVP_OFF_ACC0: st_nxt.regs.acc0 = jvp_merge(st_r.regs.acc0, st_nxt.axi.wdata, st_nxt.axi.wstrb);
                `JVP_OFF_DEC0: st_nxt.regs.dec0 = jvp_merge(st_r.regs.dec0, st_nxt.axi.wdata, st_nxt.axi.wstrb);
                `JVP_OFF_VEL1: st_nxt.regs.vel1 = jvp_merge(st_r.regs.vel1, st_nxt.axi.wdata, st_nxt.axi.wstrb);
                `JVP_OFF_ACC1: st_nxt.regs.acc1 = jvp_merge(st_r.regs.acc1, st_nxt.axi.wdata, st_nxt.axi.wstrb);
                `JVP_OFF_DEC1: st_nxt.regs.dec1 = jvp_merge(st_r.regs.dec1, st_nxt.axi.wdata, st_nxt.axi.wstrb);
                `JVP_OFF_SDEC: st_nxt.regs.sdec = jvp_merge(st_r.regs.sdec, st_nxt.axi.wdata, st_nxt.axi.wstrb);
                // Status words ignore writes but still answer OKAY
                `JVP_OFF_STAT, `JVP_OFF_CVEL: st_nxt.axi.bresp = `JVP_RESP_OKAY;
                default: st_nxt.axi.bresp = `JVP_RESP_SLVERR;
            endcase
        end
        st_nxt.axi.awready = !st_nxt.axi.aw_have && !st_nxt.axi.bvalid;
        st_nxt.axi.wready = !st_nxt.axi.w_have && !st_nxt.axi.bvalid;

        // ****************************************
        // AXI4-Lite read channel
        // ****************************************
        stat = '{zero: '0, mode: st_r.mode, ready: st_r.ready, inp: st_r.inp, dec: st_r.dec,
                 atv: st_r.atv, acc: st_r.acc, done: st_r.done, any_done: st_r.any_done};
        if (st_r.axi.rvalid && s_axi_rready) begin
            st_nxt.axi.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.axi.arready) begin
            st_nxt.axi.rvalid = 1'b1;
            st_nxt.axi.rresp = `JVP_RESP_OKAY;
            case (jvp_word(s_axi_araddr))
                `JVP_OFF_CTRL: st_nxt.axi.rdata = 32'(st_r.regs.ctrl);
                `JVP_OFF_VEL0: st_nxt.axi.rdata = st_r.regs.vel0;
                `JVP_OFF_ACC0: st_nxt.axi.rdata = st_r.regs.acc0;
                `JVP_OFF_DEC0: st_nxt.axi.rdata = st_r.regs.dec0;
                `JVP_OFF_VEL1: st_nxt.axi.rdata = st_r.regs.vel1;
                `JVP_OFF_ACC1: st_nxt.axi.rdata = st_r.regs.acc1;
                `JVP_OFF_DEC1: st_nxt.axi.rdata = st_r.regs.dec1;
                `JVP_OFF_SDEC: st_nxt.axi.rdata = st_r.regs.sdec;
                `JVP_OFF_STAT: st_nxt.axi.rdata = 32'(stat);
                `JVP_OFF_CVEL: st_nxt.axi.rdata = st_r.cmd;
                default: begin
                    st_nxt.axi.rdata = '0;
                    st_nxt.axi.rresp = `JVP_RESP_SLVERR;
                end
            endcase
        end
        st_nxt.axi.arready = !st_nxt.axi.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.mode <= S_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs, all registered
    // ****************************************
    assign s_axi_awready = st_r.axi.awready;
    assign s_axi_wready = st_r.axi.wready;
    assign s_axi_bvalid = st_r.axi.bvalid;
    assign s_axi_bresp = st_r.axi.bresp;
    assign s_axi_arready = st_r.axi.arready;
    assign s_axi_rvalid = st_r.axi.rvalid;
    assign s_axi_rdata = st_r.axi.rdata;
    assign s_axi_rresp = st_r.axi.rresp;
    assign cmd_velocity = st_r.cmd;
    assign any_jog_done_flag = st_r.any_done;
    assign jog_ready_flag = st_r.ready;
    assign profile_done_flag = st_r.done;
    assign accelerating_flag = st_r.acc;
    assign at_target_speed_flag = st_r.atv;
    assign decelerating_flag = st_r.dec;
    assign jog_active_flag = st_r.inp;

    // ****************************************
    // Assertions and covers
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_profile_zero_vel: assert property (st_r.mode == S_ATV && !st_r.act && !sel && $stable(st_r.regs.vel0)
        |-> jvp_abs(st_r.cmd) == jvp_abs(st_r.regs.vel0)) else $error("profile 0 speed wrong");
    a_both_cancel: assert property (pos && neg |-> tgt == 0) else $error("both requests not cancelled");
    a_no_sign_jump: assert property ($past(st_r.cmd) != 0 && st_r.cmd != 0
        |-> $past(st_r.cmd[31]) == st_r.cmd[31]) else $error("velocity crossed zero in one step");
    a_busy_lockout: assert property (st_r.mode == S_IDLE && busy && st_r.cmd == 0
        |=> st_r.mode == S_IDLE) else $error("jog started while busy");
    a_stop_override: assert property (stp && st_r.mode != S_IDLE
        |=> st_r.mode == S_STOP || st_r.mode == S_IDLE) else $error("stop not obeyed");
    // Older done bits of the other profile may still stand; only a new set is wrong
    a_stop_no_done: assert property (st_r.mode == S_STOP
        |=> !st_r.any_done && (st_r.done & ~$past(st_r.done)) == 2'b00) else $error("done after stop");
    a_limit_block: assert property (lp && st_r.cmd <= 0 |=> st_r.cmd <= 0)
        else $error("moved into positive limit");
    a_tick_hold: assert property (!$past(step) |-> $stable(st_r.cmd))
        else $error("velocity moved without tick");

    c_reach_speed: cover property (st_r.mode == S_ACC ##[1:200] st_r.mode == S_ATV);
    c_finish: cover property (st_r.mode == S_DEC ##1 st_r.any_done);
    c_reverse: cover property (st_r.cmd > 0 ##[1:400] st_r.cmd < 0);
    c_stop: cover property (st_r.mode == S_STOP ##[1:200] st_r.mode == S_IDLE);

endmodule

// >>> shared/jvp_cfg.svh
// Purpose: Constants for the jog velocity profile block
// Assumes: AXI4-Lite register bus, 32-bit data, byte addresses
// Notes: Included by its bare name; definitions only
`ifndef JVP_CFG_SVH
`define JVP_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define JVP_AW 8
`define JVP_OFF_CTRL 8'h00
`define JVP_OFF_VEL0 8'h04
`define JVP_OFF_ACC0 8'h08
`define JVP_OFF_DEC0 8'h0C
`define JVP_OFF_VEL1 8'h10
`define JVP_OFF_ACC1 8'h14
`define JVP_OFF_DEC1 8'h18
`define JVP_OFF_SDEC 8'h1C
`define JVP_OFF_STAT 8'h20
`define JVP_OFF_CVEL 8'h24

// ****************************************
// Control bits, responses, pin indices
// ****************************************
`define JVP_CTRL_SCURVE 0
`define JVP_CTRL_TB0 1
`define JVP_CTRL_TB1 2
`define JVP_CTRL_W 3
`define JVP_RESP_OKAY 2'b00
`define JVP_RESP_SLVERR 2'b10
`define JVP_NPIN 6
`define JVP_P_POS 0
`define JVP_P_NEG 1
`define JVP_P_SEL 2
`define JVP_P_STOP 3
`define JVP_P_LIMP 4
`define JVP_P_LIMN 5

`endif

// >>> shared/jvp_pkg.sv
// Purpose: Types shared by the jog velocity profile block
// Assumes: jvp_cfg.svh gives widths
// Notes: All state of the top module lives in jvp_state_t
`include "jvp_cfg.svh"

package jvp_pkg;

    // ****************************************
    // Motion modes, one-hot
    // ****************************************
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_ACC = 5'h02,
        S_ATV = 5'h04,
        S_DEC = 5'h08,
        S_STOP = 5'h10
    } jvp_mode_t;

    // ****************************************
    // Status word, read back from STAT
    // ****************************************
    typedef struct packed {
        logic [14:0] zero;
        jvp_mode_t mode;
        logic ready;
        logic [1:0] inp;
        logic [1:0] dec;
        logic [1:0] atv;
        logic [1:0] acc;
        logic [1:0] done;
        logic any_done;
    } jvp_status_t;

    typedef struct packed {
        logic [`JVP_CTRL_W-1:0] ctrl;
        logic signed [31:0] vel0;
        logic [31:0] acc0;
        logic [31:0] dec0;
        logic signed [31:0] vel1;
        logic [31:0] acc1;
        logic [31:0] dec1;
        logic [31:0] sdec;
    } jvp_regs_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [`JVP_AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } jvp_axi_t;

    typedef struct packed {
        logic [`JVP_NPIN-1:0] s1;
        logic [`JVP_NPIN-1:0] s2;
        logic [`JVP_NPIN-1:0] s3;
        logic [`JVP_NPIN-1:0] filt;
        jvp_mode_t mode;
        logic signed [31:0] cmd;
        logic act;
        logic any_done;
        logic ready;
        logic [1:0] done;
        logic [1:0] acc;
        logic [1:0] atv;
        logic [1:0] dec;
        logic [1:0] inp;
        jvp_regs_t regs;
        jvp_axi_t axi;
    } jvp_state_t;

endpackage

// >>> verif/jvp_drive_model.sv
// Purpose: Far-side drive loop that paces the jog block and consumes its velocity
// Assumes: Loop update every 4 clocks, master-axis pulse every 8 clocks
// Notes: Position is integrated only to load the command the way a real loop does
`timescale 1ns/1ps

module jvp_drive_model (
    input wire logic aclk, // 125 MHz clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic signed [31:0] cmd_velocity, // Velocity command in
    output logic motion_tick, // Loop update pulse
    output logic sync_tick // Master-axis pulse
);
    typedef struct packed {
        logic [2:0] cnt;
        logic signed [47:0] pos;
    } jvp_drv_t;
    jvp_drv_t st_r;
    jvp_drv_t st_nxt;

    // ****************************************
    // Tick pacing
    // ****************************************
    // Sync pulse always lands on a loop pulse, so synchronized ramps step every 8 clocks
    assign motion_tick = (st_r.cnt[1:0] == 2'h3);
    assign sync_tick = (st_r.cnt == 3'h7);

    always_comb begin
        st_nxt = st_r;
        st_nxt.cnt = st_r.cnt + 3'h1;
        if (motion_tick) begin
            st_nxt.pos = st_r.pos + {{16{cmd_velocity[31]}}, cmd_velocity};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// >>> verif/jvp_top_tb.sv
// Purpose: Self-checking bench for the jog velocity profile block
// Assumes: Results are read back over AXI4-Lite from CVEL and STAT
// Notes: Each read notes its expectation; the monitor compares on rvalid
`timescale 1ns/1ps
`include "jvp_cfg.svh"

module jvp_top_tb;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic jog_positive_request = 1'b0, jog_negative_request = 1'b0, jog_profile_select = 1'b0;
    logic stop_request = 1'b0, limit_positive = 1'b0, limit_negative = 1'b0;
    logic homing_busy = 1'b0, index_busy = 1'b0, program_busy = 1'b0;
    logic motion_tick, sync_tick, any_jog_done_flag, jog_ready_flag;
    logic signed [31:0] cmd_velocity, v1;
    logic [1:0] profile_done_flag, accelerating_flag, at_target_speed_flag, decelerating_flag, jog_active_flag;
    logic [65:0] exp_q[$];
    logic [65:0] q_e;
    integer n_fail = 0, compares = 0, seed = 32'hBCDA, i;

    jvp_top dut (.*);
    jvp_drive_model drv (.aclk(aclk), .aresetn(aresetn), .cmd_velocity(cmd_velocity),
        .motion_tick(motion_tick), .sync_tick(sync_tick));

    // ****************************************
    // Clock, watchdog, closing
    // ****************************************
    initial begin
        forever #4 aclk = ~aclk;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_fail = n_fail + 1;
        complete_run;
    end

    task complete_run;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares = compares + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ****************************************
    // Bus master and monitor
    // ****************************************
    task wr(input logic [7:0] a, input logic [31:0] d);
        rnd = $random(seed);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awprot <= rnd[2:0];
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] m, input logic [33:0] e);
        rnd = $random(seed);
        exp_q.push_back({m, e});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arprot <= rnd[2:0];
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    task rv(input logic [31:0] v);
        rd(`JVP_OFF_CVEL, ALL, {`JVP_RESP_OKAY, v});
    endtask

    task rs(input logic [31:0] m, input logic [31:0] v);
        rd(`JVP_OFF_STAT, m, {`JVP_RESP_OKAY, v});
    endtask

    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            q_e = exp_q.pop_front();
            chk("rdata", q_e[31:0], s_axi_rdata & q_e[65:34]);
            chk("rresp", {30'h0, q_e[33:32]}, {30'h0, s_axi_rresp});
        end
    end

    // Settle long enough for the slowest ramp: four synchronized steps each way
    task jog(input logic p, input logic n, input logic s);
        @(posedge aclk);
        jog_positive_request <= p;
        jog_negative_request <= n;
        jog_profile_select <= s;
        repeat (100) @(posedge aclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rs(ALL, 32'h1800);
        rnd = $random(seed);
        v1 = 32'h0 - 32'h32 * (32'h1 + {30'h0, rnd[1:0]});
        wr(`JVP_OFF_CTRL, 32'h5);
        wr(`JVP_OFF_VEL0, 32'h64);
        wr(`JVP_OFF_ACC0, 32'h32);
        wr(`JVP_OFF_DEC0, 32'h32);
        wr(`JVP_OFF_VEL1, v1);
        wr(`JVP_OFF_ACC1, 32'h32);
        wr(`JVP_OFF_DEC1, 32'h32);
        wr(`JVP_OFF_SDEC, 32'h64);
        rd(`JVP_OFF_CTRL, ALL, {`JVP_RESP_OKAY, 32'h5});
        rd(8'h40, ALL, {`JVP_RESP_SLVERR, 32'h0});
        jog(1'b1, 1'b0, 1'b0);
        rv(32'h64);
        rs(ALL, 32'h4220);
        jog(1'b0, 1'b0, 1'b0);
        rv(32'h0);
        rs(ALL, 32'h1803);
        jog(1'b0, 1'b1, 1'b0);
        rv(-32'sh64);
        jog(1'b1, 1'b1, 1'b0);
        rv(32'h0);
        rs(32'h800, 32'h800);
        jog(1'b1, 1'b0, 1'b1);
        rv(v1);
        jog(1'b1, 1'b0, 1'b0);
        rv(32'h64);
        jog(1'b0, 1'b1, 1'b1);
        rv(-v1);
        @(posedge aclk);
        stop_request <= 1'b1;
        repeat (100) @(posedge aclk);
        rv(32'h0);
        rs(32'h1801, 32'h1800);
        jog(1'b0, 1'b0, 1'b0);
        stop_request <= 1'b0;
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge aclk);
            {program_busy, index_busy, homing_busy} <= 3'b001 << i;
            jog(1'b1, 1'b0, 1'b0);
            rv(32'h0);
            jog(1'b0, 1'b0, 1'b0);
            {program_busy, index_busy, homing_busy} <= 3'b000;
        end
        @(posedge aclk);
        limit_positive <= 1'b1;
        jog(1'b0, 1'b1, 1'b0);
        rv(-32'sh64);
        jog(1'b1, 1'b0, 1'b0);
        rv(32'h0);
        jog(1'b0, 1'b0, 1'b0);
        complete_run;
    end
endmodule
